// ### hdl/sar_link_pkg.sv
`default_nettype none
package sar_link_pkg;
   // =====================================================
   // widths and timing
   localparam int unsigned DATA_W        = 16;
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned CONV_MIN_NS   = 500;
   localparam int unsigned CONV_MAX_NS   = 2200;
   localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
   // least time rounds up, longest rounds down
   localparam int unsigned CONV_MIN_CYC  = (CONV_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned CONV_MAX_CYC  = CONV_MAX_NS / CLK_NS;
   localparam int unsigned SCLK_HALF_CYC = 4;
   // =====================================================
   // result saturation and reset codes
   localparam logic [15:0] CODE_POS_FULL = 16'h7fff;
   localparam logic [15:0] CODE_NEG_FULL = 16'h8000;
   localparam logic [15:0] RESET_WORD    = 16'h0000;
   // =====================================================
   // host command register map
   localparam logic [1:0]  ADDR_CTRL     = 2'h0;
   localparam logic [1:0]  ADDR_STATUS   = 2'h1;
   localparam logic [1:0]  ADDR_DATA     = 2'h2;
   localparam logic [1:0]  ADDR_CHAIN    = 2'h3;
   localparam int unsigned CTRL_GO_BIT   = 0;
   localparam int unsigned CTRL_BUSY_BIT = 1;
   localparam int unsigned CTRL_CHN_BIT  = 2;
   // =====================================================
   typedef enum logic [1:0] {MODE_NONE, MODE_SEL, MODE_CHAIN} mode_t;
   // sign-saturate a wider sample into the result word
   function automatic logic [15:0] sat16(input logic signed [17:0] v);
      if (v > 18'sd32767) begin
         return CODE_POS_FULL;
      end else if (v < -18'sd32768) begin
         return CODE_NEG_FULL;
      end else begin
         return v[15:0];
      end
   endfunction
endpackage
`default_nettype wire

// ### hdl/sar_link_if.sv
`default_nettype none
interface sar_link_if;
   logic conv_start;
   logic sel_in;
   logic sclk;
   logic sdo_o;
   logic sdo_oe;
   logic serial_data_output;
   // pull-up on the data line resolves a released pin to one
   assign serial_data_output = sdo_oe ? sdo_o : 1'b1;
   modport device (input conv_start, input sel_in, input sclk, output sdo_o, output sdo_oe);
   modport host   (output conv_start, output sel_in, output sclk, input serial_data_output);
endinterface
`default_nettype wire

// ### hdl/edge_sync.sv
`default_nettype none
// two-flop synchroniser plus edge finder on the second stage
module edge_sync (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic d_i,
   output logic      lvl_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic [2:0] sh_ff;
   // =====================================================
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sh_ff <= 3'h0;
      end else begin
         sh_ff <= {sh_ff[1:0], d_i};
      end
   end
   assign lvl_o  = sh_ff[1];
   assign rise_o = sh_ff[1] & ~sh_ff[2];
   assign fall_o = ~sh_ff[1] & sh_ff[2];
endmodule
`default_nettype wire

// ### hdl/sar_device.sv
`default_nettype none
// Operation
// R1: cnv rise samples select: high select, low chain
// R2: select tied to start always gives chain
// R3: host clocks out one word after power-up; host here idles until a go write to the control register
// R4: optional start bit, else wait max time
// R5: select busy if start or select low
// R6: chain busy if serial clock high
// R7: select high start rise: convert, release line
// R8: conversion always runs to its end
// R9: host may drop start, restore before min
// R10: end of conversion powers down to acquire
// R11: no busy: msb on start fall, fall shifts
// R12: bits stay valid across both clock edges
// R13: no busy: release after 16th fall/rise
// R14: busy: line released until conversion done
// R15: host holds start low for busy
// R16: busy: drive low when conversion completes
// R17: busy: shift msb first, release after 17th
// R18: 4-wire: select governs readout timing
// R19: chain: select feeds output shift register
// R20: conversion timed by internal clock
// R21: result saturates at 7fff and 8000
// R22: host holds min and max conversion time
// R23: host drops start bit into 16-bit word
module sar_device #(
   parameter int unsigned CONV_CYC = sar_link_pkg::CONV_MAX_CYC
) (
   input  wire logic               clk_i,
   input  wire logic               rstn_i,
   input  wire logic signed [17:0] sample_i,
   output logic                    powered_o,
   output logic                    busy_mode_o,
   sar_link_if.device              link
);
   // =====================================================
   // synchronised pins
   logic cnv_l, cnv_r, cnv_f, sel_l, sel_r, sel_f, sck_l, sck_r, sck_f;
   edge_sync u_cnv (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(link.conv_start),
                    .lvl_o(cnv_l), .rise_o(cnv_r), .fall_o(cnv_f));
   edge_sync u_sel (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(link.sel_in),
                    .lvl_o(sel_l), .rise_o(sel_r), .fall_o(sel_f));
   edge_sync u_sck (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(link.sclk),
                    .lvl_o(sck_l), .rise_o(sck_r), .fall_o(sck_f));

   typedef struct packed {
      sar_link_pkg::mode_t mode;
      logic               converting;
      logic [15:0]        timer;
      logic               busy;
      logic [16:0]        shreg;
      logic [4:0]         cnt;
      logic               serial_data_output;
      logic               oe;
      logic               pwr;
      logic               sel_prev;
   } state_t;
   state_t st_ff, nxt_st;

   // =====================================================
   // mode choice, conversion timer, readout shifter
   always_comb begin
      nxt_st = st_ff;
      nxt_st.sel_prev = sel_l;
      if (cnv_r) begin
         // edge is seen with select's level before any shared-wire change
         if (!st_ff.converting) begin // R8
            nxt_st.converting = 1'b1; // R20
            nxt_st.timer      = 16'(CONV_CYC);
            nxt_st.pwr        = 1'b1;
            nxt_st.cnt        = 5'h0;
            // tied select rises with start: sampled prior value low, chain
            if (st_ff.sel_prev) begin // R1 R2
               nxt_st.mode = sar_link_pkg::MODE_SEL;
               nxt_st.oe   = 1'b0; // R7 R14
               nxt_st.busy = 1'b0;
            end else begin
               nxt_st.mode = sar_link_pkg::MODE_CHAIN;
               nxt_st.busy = sck_l; // R6
               nxt_st.oe   = 1'b1;
               nxt_st.serial_data_output  = 1'b0;
            end
         end
         if (st_ff.mode == sar_link_pkg::MODE_SEL) begin
            nxt_st.oe = 1'b0; // R13 R17
         end
      end else if (st_ff.converting) begin
         nxt_st.timer = st_ff.timer - 16'h1;
         if (st_ff.timer == 16'h1) begin
            nxt_st.converting = 1'b0;
            nxt_st.pwr        = 1'b0; // R10
            nxt_st.shreg      = {sar_link_pkg::sat16(sample_i), 1'b0}; // R21
            if (st_ff.mode == sar_link_pkg::MODE_SEL) begin
               nxt_st.busy = ~cnv_l | ~sel_l; // R5
               if (~cnv_l | ~sel_l) begin
                  nxt_st.oe  = 1'b1; // R16
                  nxt_st.serial_data_output = 1'b0;
                  nxt_st.cnt = 5'h0;
                  // start bit stands first, so the msb leaves on the first fall
                  nxt_st.shreg = {1'b0, sar_link_pkg::sat16(sample_i)}; // R17
               end
            end else begin
               nxt_st.oe  = 1'b1;
               nxt_st.serial_data_output = st_ff.busy ? 1'b1 : sar_link_pkg::sat16(sample_i)[15];
               nxt_st.cnt = st_ff.busy ? 5'h0 : 5'h1;
               nxt_st.shreg = st_ff.busy ? {sar_link_pkg::sat16(sample_i), 1'b0}
                                         : {sar_link_pkg::sat16(sample_i)[14:0], 2'h0};
            end
         end
      end else if (st_ff.mode == sar_link_pkg::MODE_SEL) begin
         // 3-wire uses start, 4-wire uses select as the read strobe
         if (!st_ff.busy && (cnv_f || sel_f) && !st_ff.oe) begin // R11 R18
            nxt_st.oe  = 1'b1;
            nxt_st.serial_data_output = st_ff.shreg[16];
            nxt_st.cnt = 5'h1;
         end else if (st_ff.oe && sck_f) begin
            // bit changes only on falls, so it holds over the rise
            nxt_st.serial_data_output   = st_ff.shreg[15]; // R12 R17
            nxt_st.shreg = {st_ff.shreg[15:0], 1'b0};
            nxt_st.cnt   = st_ff.cnt + 5'h1;
            if (st_ff.cnt == 5'(sar_link_pkg::DATA_W)) begin
               nxt_st.oe = 1'b0; // R13 R17
            end
         end
         if (sel_r && !st_ff.busy && cnv_l) begin
            nxt_st.oe = 1'b0;
         end
      end else if (st_ff.mode == sar_link_pkg::MODE_CHAIN && sck_f) begin
         nxt_st.serial_data_output   = st_ff.shreg[16]; // R19
         nxt_st.shreg = {st_ff.shreg[15:0], sel_l};
         if (st_ff.cnt != 5'h1f) begin
            nxt_st.cnt = st_ff.cnt + 5'h1;
         end
      end
   end

   // =====================================================
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign link.sdo_o   = st_ff.serial_data_output;
   assign link.sdo_oe  = st_ff.oe;
   assign powered_o    = st_ff.pwr;
   assign busy_mode_o  = st_ff.busy;
endmodule
`default_nettype wire

// ### hdl/sar_host.sv
`default_nettype none
// 3-wire select-mode reader with own register port
module sar_host #(
   parameter int unsigned MIN_CYC = sar_link_pkg::CONV_MIN_CYC,
   parameter int unsigned MAX_CYC = sar_link_pkg::CONV_MAX_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic [1:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [15:0] rdata_o,
   sar_link_if.host         link
);
   typedef enum logic [2:0] {H_IDLE, H_CONV, H_WAITIRQ, H_READ, H_DONE} hst_t;
   typedef struct packed {
      hst_t        st;
      logic        busy_mode;
      logic [15:0] timer;
      logic [5:0]  bits;
      logic [2:0]  div;
      logic [16:0] rx;
      logic [15:0] result;
      logic        valid;
      logic        conversion_start_pin;
      logic        sck;
      logic [15:0] rdata;
      logic [1:0]  sync;
   } hs_t;
   hs_t h_ff, nxt_h;
   logic sdo_s;
   assign sdo_s = h_ff.sync[1];

   // =====================================================
   always_comb begin
      nxt_h = h_ff;
      nxt_h.sync = {h_ff.sync[0], link.serial_data_output};
      nxt_h.rdata = 16'h0;
      case (h_ff.st)
         H_IDLE: begin
            nxt_h.conversion_start_pin = 1'b0;
            if (wr_i && addr_i == sar_link_pkg::ADDR_CTRL && wdata_i[0]) begin
               nxt_h.busy_mode = wdata_i[1];
               nxt_h.conversion_start_pin   = 1'b1;
               nxt_h.timer = 16'h0;
               nxt_h.valid = 1'b0;
               nxt_h.st    = H_CONV;
            end
         end
         H_CONV: begin
            nxt_h.timer = h_ff.timer + 16'h1; // R22
            // busy mode: start pin low well before the minimum time
            if (h_ff.busy_mode) begin
               nxt_h.conversion_start_pin = 1'b0; // R15
            end else begin
               nxt_h.conversion_start_pin = 1'b1; // R9
            end
            if (h_ff.timer == 16'(MAX_CYC + 4)) begin // R4
               nxt_h.bits = 6'h0;
               nxt_h.div  = 3'h0;
               nxt_h.st   = h_ff.busy_mode ? H_WAITIRQ : H_READ;
               nxt_h.conversion_start_pin  = 1'b0; // R11
            end
         end
         H_WAITIRQ: begin
            if (!sdo_s) begin // R16
               nxt_h.st = H_READ;
            end
         end
         H_READ: begin
            nxt_h.div = h_ff.div + 3'h1;
            if (h_ff.div == 3'(sar_link_pkg::SCLK_HALF_CYC - 1)) begin
               nxt_h.div = 3'h0;
               nxt_h.sck = ~h_ff.sck;
               if (h_ff.sck) begin
                  // capture just before the fall: sync lag on both ends means a
                  // new bit shows here only late in the period
                  nxt_h.rx   = {h_ff.rx[15:0], sdo_s}; // R12
                  nxt_h.bits = h_ff.bits + 6'h1;
                  if (h_ff.bits == 6'(sar_link_pkg::DATA_W + (h_ff.busy_mode ? 1 : 0) - 1)) begin
                     nxt_h.st = H_DONE;
                  end
               end
            end
         end
         default: begin
            nxt_h.result = h_ff.rx[15:0]; // R23
            nxt_h.valid  = 1'b1;
            // start pin stays low: a rise here would launch an unwanted conversion
            nxt_h.conversion_start_pin    = 1'b0;
            nxt_h.sck    = 1'b0;
            nxt_h.st     = H_IDLE;
         end
      endcase
      if (rd_i) begin
         if (addr_i == sar_link_pkg::ADDR_STATUS) begin
            nxt_h.rdata = {13'h0, h_ff.busy_mode, h_ff.st != H_IDLE, h_ff.valid};
         end else if (addr_i == sar_link_pkg::ADDR_DATA) begin
            nxt_h.rdata = h_ff.result;
         end else begin
            nxt_h.rdata = 16'h0;
         end
      end
   end

   // =====================================================
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         h_ff <= '0;
      end else begin
         h_ff <= nxt_h;
      end
   end

   assign link.conv_start = h_ff.conversion_start_pin;
   assign link.sel_in     = 1'b1; // 3-wire: select held high
   assign link.sclk       = h_ff.sck;
   assign rdata_o         = h_ff.rdata;
endmodule
`default_nettype wire

// ### dv/sar_link_sva.sv
`default_nettype none
// watches the shared link between the two ends
module sar_link_sva (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic conv_start,
   input wire logic sel_in,
   input wire logic sclk,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic serial_data_output
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // ==========
   // helper counters
   logic [4:0] nfall_ff; // raw serial clock falls while line is driven
   logic [7:0] low_ff;   // cycles since start pin went low
   logic [3:0] since_ff; // cycles since last serial clock fall
   // counters saturate so a long idle never wraps into a false match
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         nfall_ff <= 5'h00;
         low_ff   <= 8'h00;
         since_ff <= 4'hf;
      end else begin
         nfall_ff <= !sdo_oe ? 5'h00 : nfall_ff + {4'h0, $fell(sclk) && nfall_ff != 5'h1f};
         low_ff   <= conv_start ? 8'h00 : low_ff + {7'h0, low_ff != 8'hff};
         since_ff <= $fell(sclk) ? 4'h0 : since_ff + {3'h0, since_ff != 4'hf};
      end
   end
   // ==========
   // link properties
   sequence s_conv_begin;
      $rose(conv_start) && sel_in;
   endsequence
   sequence s_line_off;
      ##4 !sdo_oe [*8];
   endsequence
   a_start_release: assert property (s_conv_begin |-> ##[1:4] !sdo_oe)
      else $error("line still driven after start");
   a_conv_hiz: assert property (s_conv_begin |-> s_line_off)
      else $error("line driven during conversion");
   a_sclk_quiet: assert property (s_conv_begin |-> !sclk [*8])
      else $error("serial clock moved during conversion");
   a_busy_low: assert property ($rose(sdo_oe) && !conv_start && low_ff > 8'd8 |-> !serial_data_output)
      else $error("busy start bit not low");
   a_bit_stable: assert property ($rose(sclk) && sdo_oe |-> ##1 $stable(sdo_o) [*3])
      else $error("data moved around rising clock");
   a_shift_fall: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo_o)
      |-> since_ff <= 4'd5)
      else $error("data moved without clock fall");
   a_release_cap: assert property (nfall_ff == 5'd17 |-> ##[0:4] !sdo_oe)
      else $error("line held past last bit");
   a_early_release: assert property ($fell(sdo_oe) |-> nfall_ff >= 5'd16 || conv_start)
      else $error("line released too early");
endmodule
`default_nettype wire

// ### dv/sar_adc_serial_readout_control_test.sv
`default_nettype none
module sar_adc_serial_readout_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned CONV = 30; // lengthened conversion count
   logic               clk_i    = 1'b0;
   logic               rstn_i   = 1'b0;
   logic signed [17:0] sample_i = 18'sd0;
   logic        [1:0]  addr_i   = 2'h0;
   logic        [15:0] wdata_i  = 16'h0000;
   logic               wr_i     = 1'b0;
   logic               rd_i     = 1'b0;
   logic               pend     = 1'b0;
   logic        [15:0] rdata_o;
   logic               powered_o;
   logic               busy_mode_o;
   logic        [15:0] exp_q[$];
   int                 n_mismatch = 0;
   int                 cmp_count  = 0;
   int                 cyc        = 0;
   sar_link_if link ();
   sar_device #(.CONV_CYC(CONV)) u_sar_device (.clk_i(clk_i), .rstn_i(rstn_i),
      .sample_i(sample_i), .powered_o(powered_o), .busy_mode_o(busy_mode_o), .link(link));
   sar_host #(.MIN_CYC(5), .MAX_CYC(CONV)) u_sar_host (.clk_i(clk_i), .rstn_i(rstn_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .link(link));
   sar_link_sva u_sar_link_sva (.clk_i(clk_i), .rstn_i(rstn_i), .conv_start(link.conv_start),
      .sel_in(link.sel_in), .sclk(link.sclk), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe),
      .serial_data_output(link.serial_data_output));
   // ==========
   // clock and hang guard
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   // ==========
   // compare and report
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // expected word: clip to the signed 16-bit range
   function automatic logic [15:0] clip(input logic signed [17:0] v);
      if (v > 18'sd32767) return 16'h7fff;
      if (v < -18'sd32768) return 16'h8000;
      return v[15:0];
   endfunction
   // ==========
   // register port master
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [15:0] q);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      @(negedge clk_i);
      q = rdata_o;
   endtask
   // data reads are checked here, against the oldest note
   always @(posedge clk_i) pend <= rd_i && addr_i == sar_link_pkg::ADDR_DATA;
   always @(negedge clk_i) begin
      if (pend && exp_q.size() > 0) begin
         chk(rdata_o, exp_q.pop_front());
      end
   end
   // one full start, wait and readout in the chosen mode
   task automatic run(input logic busy, input int k);
      logic [15:0] st;
      logic [15:0] d;
      logic [31:0] r;
      int          n;
      r = $urandom();
      d = 16'h0000;
      d[sar_link_pkg::CTRL_GO_BIT]   = 1'b1;
      d[sar_link_pkg::CTRL_BUSY_BIT] = busy;
      case (k)
         0: sample_i <= 18'sd40000;
         1: sample_i <= -18'sd40000;
         2: sample_i <= 18'sd32767;
         default: sample_i <= {{2{r[15]}}, r[15:0]};
      endcase
      wr(sar_link_pkg::ADDR_CTRL, d);
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      chk({15'h0, powered_o}, 16'h0001);
      n = 0;
      do begin
         rd(sar_link_pkg::ADDR_STATUS, st);
         n++;
      end while (st[1] !== 1'b0 && n < 600);
      chk({15'h0, st[0]}, 16'h0001);
      chk({15'h0, busy_mode_o}, {15'h0, busy});
      chk({15'h0, powered_o}, 16'h0000);
      exp_q.push_back(clip(sample_i));
      rd(sar_link_pkg::ADDR_DATA, st);
   endtask
   // ==========
   // main sequence: both modes, saturating and in-range inputs
   initial begin
      void'($urandom(32'h71e4fff5));
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      for (int b = 0; b < 2; b++) begin
         for (int k = 0; k < 5; k++) begin
            run(b[0], k);
         end
      end
      repeat (4) @(posedge clk_i);
      complete_run();
   end
endmodule
`default_nettype wire
